/* File: rtl/fsi_consts.vh */
`ifndef FSI_CONSTS_VH
`define FSI_CONSTS_VH

// Register indices; the APB byte address is four times the index
`define FSI_IDX_CTRL 6'h30
`define FSI_IDX_SYNC_EN 6'h31
`define FSI_IDX_EDGE_LO 6'h32
`define FSI_IDX_EDGE_HI 6'h33
`define FSI_IDX_SYNC_CAUSE 6'h34
`define FSI_IDX_HDONE 6'h35
`define FSI_IDX_STATUS 6'h36
`define FSI_IDX_OUT_BYTE 6'h37
`define FSI_IDX_COMM 6'h38
`define FSI_IDX_EVT_LOG 6'h39
`define FSI_IDX_OUT_RST_LOG 6'h3A
`define FSI_IDX_CAUSE 6'h3C

// Control register fields
`define FSI_CTRL_AEN_LSB 0
`define FSI_CTRL_AEN_MSB 3
`define FSI_CTRL_PARAM_OK 4
`define FSI_CTRL_ASYNC_LOADED 5
`define FSI_CTRL_SYNC_LOADED 6
`define FSI_CTRL_DISPATCH_EN 7
`define FSI_CTRL_SAME_GROUP 8
`define FSI_CTRL_PASSIVATE 9
`define FSI_CTRL_AUTO_PASSIVATE 10
`define FSI_CTRL_MSB 10
`define FSI_CTRL_RESET 11'h080

// Cause byte: the four dedicated inputs land on bits 7..4
`define FSI_CAUSE_LSB 4
`define FSI_CAUSE_MSB 7

// Edge selection codes, two bits per synchronous pin input; each cnt_match input has one enable bit
`define FSI_EDGE_FALL 2'h0
`define FSI_EDGE_RISE 2'h1
`define FSI_EDGE_HI_CNT_LSB 8
`define FSI_EDGE_HI_CNT_MSB 9

// Status and handler-done fields
`define FSI_STAT_ASYNC_BUSY 0
`define FSI_STAT_SYNC_BUSY 1
`define FSI_STAT_OUT_EN 2
`define FSI_STAT_DISC_LSB 4
`define FSI_STAT_DISC_MSB 7
`define FSI_HDONE_ASYNC 0
`define FSI_HDONE_SYNC 1

// Sizes and reset values
`define FSI_NSYNC 22
`define FSI_NPIN 20
`define FSI_ZERO8 8'h00
`define FSI_OUT_RESET 8'hFF
`define FSI_CNT_ZERO 17'h0_0000

// Discrepancy window timing
`define FSI_DISC_WINDOW_US 1000
`define FSI_CLK_MHZ 100

`endif

/* File: rtl/fsi_irq_logic.v */
`timescale 1ns/100ps
`default_nettype none
`include "fsi_consts.vh"

module fsi_irq_logic #(
   parameter [16:0] DISC_CYCLES = `FSI_DISC_WINDOW_US * `FSI_CLK_MHZ
)(
   // Clock, reset, clock enable
   input wire pclk,
   input wire presetn,
   input wire pclken,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Field inputs, one copy per subunit except the single cnt_match pair
   input wire [3:0] irq_in_a,
   input wire [3:0] irq_in_b,
   input wire [15:0] digital_input_a,
   input wire [15:0] digital_input_b,
   input wire [1:0] cnt_match,
   // Controller state
   input wire powered,
   input wire run_mode,
   input wire insn_boundary,
   // Dispatch outputs
   output reg async_irq_handler,
   output reg [3:0] async_irq_src,
   output reg sync_irq_handler,
   output reg [21:0] sync_irq_src,
   output reg resume_pulse,
   // Onboard output byte and diagnostics
   output reg [7:0] onboard_out,
   output reg out_byte_enable,
   output reg [7:0] input_image
);

   // Register state
   reg [`FSI_CTRL_MSB:0] ctrl_reg;
   reg [19:0] sync_en_reg;
   reg [31:0] edge_lo_reg;
   reg [9:0] edge_hi_reg;
   reg [21:0] sync_cause_reg;
   reg [7:0] out_byte_reg;
   reg [7:0] comm_reg;
   reg [7:0] evt_log_reg;
   reg [7:0] out_rst_log_reg;
   reg [7:0] cause_reg;
   reg [3:0] disc_err_reg;
   reg [3:0] async_lvl_reg;
   reg [15:0] di_lvl_reg;
   reg [3:0] async_pend_reg;
   reg [21:0] sync_pend_reg;
   reg [16:0] disc_cnt_reg [0:3];
   integer i;
   integer j;

   // Selects a register by index on the current APB address
   function sel_idx;
      input [7:0] addr;
      input [5:0] idx;
      begin
         sel_idx = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
      end
   endfunction

   // Decides whether a level pair shows the configured edge
   function edge_hit;
      input [1:0] mode;
      input prev;
      input now;
      begin
         if (mode == `FSI_EDGE_FALL)
            edge_hit = prev & ~now;
         else if (mode == `FSI_EDGE_RISE)
            edge_hit = ~prev & now;
         else
            edge_hit = prev ^ now;
      end
   endfunction

   // Bus decode
   wire wr_acc = psel & penable & pwrite & pclken;
   wire rd_setup = psel & ~penable & ~pwrite;
   wire hit = sel_idx(paddr, `FSI_IDX_CTRL) | sel_idx(paddr, `FSI_IDX_SYNC_EN) |
              sel_idx(paddr, `FSI_IDX_EDGE_LO) | sel_idx(paddr, `FSI_IDX_EDGE_HI) |
              sel_idx(paddr, `FSI_IDX_SYNC_CAUSE) | sel_idx(paddr, `FSI_IDX_HDONE) |
              sel_idx(paddr, `FSI_IDX_STATUS) | sel_idx(paddr, `FSI_IDX_OUT_BYTE) |
              sel_idx(paddr, `FSI_IDX_COMM) | sel_idx(paddr, `FSI_IDX_EVT_LOG) |
              sel_idx(paddr, `FSI_IDX_OUT_RST_LOG) | sel_idx(paddr, `FSI_IDX_CAUSE);
   assign pready = pclken;
   assign pslverr = psel & penable & ~hit;

   // Register write strobes
   wire wr_ctrl = wr_acc & sel_idx(paddr, `FSI_IDX_CTRL);
   wire wr_sync_en = wr_acc & sel_idx(paddr, `FSI_IDX_SYNC_EN);
   wire wr_edge_lo = wr_acc & sel_idx(paddr, `FSI_IDX_EDGE_LO);
   wire wr_edge_hi = wr_acc & sel_idx(paddr, `FSI_IDX_EDGE_HI);
   wire wr_scause = wr_acc & sel_idx(paddr, `FSI_IDX_SYNC_CAUSE);
   wire wr_hdone = wr_acc & sel_idx(paddr, `FSI_IDX_HDONE);
   wire wr_status = wr_acc & sel_idx(paddr, `FSI_IDX_STATUS);
   wire wr_out = wr_acc & sel_idx(paddr, `FSI_IDX_OUT_BYTE);
   wire wr_comm = wr_acc & sel_idx(paddr, `FSI_IDX_COMM);
   wire wr_evt = wr_acc & sel_idx(paddr, `FSI_IDX_EVT_LOG);
   wire wr_orst = wr_acc & sel_idx(paddr, `FSI_IDX_OUT_RST_LOG);
   wire wr_cause = wr_acc & sel_idx(paddr, `FSI_IDX_CAUSE);

   // Combined channel levels; low as soon as either channel is low
   wire [3:0] async_lvl = irq_in_a & irq_in_b;
   wire [15:0] di_lvl = digital_input_a & digital_input_b;
   wire [3:0] async_en = ctrl_reg[`FSI_CTRL_AEN_MSB:`FSI_CTRL_AEN_LSB];

   // Async events on falling edge of an enabled input only
   wire [3:0] async_evt = async_lvl_reg & ~async_lvl & async_en;

   // Sync events per pin input on the selected edge; cnt_match inputs while high and enabled
   reg [21:0] sync_evt;
   reg [1:0] mode;
   always @*
   begin
      sync_evt = 22'h00_0000;
      mode = `FSI_EDGE_FALL;
      for (i = 0; i < `FSI_NPIN; i = i + 1)
      begin
         if (i < 16)
            mode = edge_lo_reg[2*i +: 2];
         else
            mode = edge_hi_reg[2*(i-16) +: 2];
         // AND level falls on first subunit, rises only when both have risen
         if (i < 16)
            sync_evt[i] = sync_en_reg[i] & edge_hit(mode, di_lvl_reg[i], di_lvl[i]);
         else
            sync_evt[i] = sync_en_reg[i] & edge_hit(mode, async_lvl_reg[i-16], async_lvl[i-16]);
      end
      sync_evt[21:20] = cnt_match & edge_hi_reg[`FSI_EDGE_HI_CNT_MSB:`FSI_EDGE_HI_CNT_LSB];
   end

   // Dispatch gating
   wire gate_ok = ctrl_reg[`FSI_CTRL_PARAM_OK] & powered & run_mode &
                  ctrl_reg[`FSI_CTRL_DISPATCH_EN] & insn_boundary;
   wire async_go = gate_ok & (|async_pend_reg) & ~async_irq_handler;
   wire sync_go = gate_ok & (|sync_pend_reg) & ~async_irq_handler & ~sync_irq_handler & ~async_go;
   wire async_loaded = ctrl_reg[`FSI_CTRL_ASYNC_LOADED];
   wire sync_loaded = ctrl_reg[`FSI_CTRL_SYNC_LOADED];

   // Passivation and output byte enable
   wire passivated = ctrl_reg[`FSI_CTRL_PASSIVATE] |
                     (ctrl_reg[`FSI_CTRL_AUTO_PASSIVATE] & (|disc_err_reg));
   wire out_en_next = ~(passivated & ctrl_reg[`FSI_CTRL_SAME_GROUP]);

   // Writes to the output byte; inside the async handler only resets are kept
   wire [7:0] out_wdata = pwdata[7:0];
   wire [7:0] out_cleared = async_irq_handler ? (out_byte_reg & ~out_wdata) : `FSI_ZERO8;
   wire [7:0] out_next = async_irq_handler ? (out_byte_reg & out_wdata) : out_wdata;

   // Configuration registers and communication byte
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= `FSI_CTRL_RESET;
         sync_en_reg <= 20'h0_0000;
         edge_lo_reg <= 32'h0000_0000;
         edge_hi_reg <= 10'h000;
         comm_reg <= `FSI_ZERO8;
         out_byte_reg <= `FSI_OUT_RESET;
      end
      else if (pclken)
      begin
         if (wr_ctrl)
            ctrl_reg <= pwdata[`FSI_CTRL_MSB:0];
         if (wr_sync_en)
            sync_en_reg <= pwdata[19:0];
         if (wr_edge_lo)
            edge_lo_reg <= pwdata;
         if (wr_edge_hi)
            edge_hi_reg <= pwdata[9:0];
         if (wr_comm && !async_irq_handler)
            comm_reg <= pwdata[7:0];
         if (wr_out)
            out_byte_reg <= out_next;
      end
   end

   // Level history of both input groups
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         async_lvl_reg <= 4'hF;
         di_lvl_reg <= 16'hFFFF;
      end
      else if (pclken)
      begin
         async_lvl_reg <= async_lvl;
         di_lvl_reg <= di_lvl;
      end
   end

   // Discrepancy timers; a mismatch lasting the window latches an error
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (j = 0; j < 4; j = j + 1)
            disc_cnt_reg[j] <= `FSI_CNT_ZERO;
         disc_err_reg <= 4'h0;
      end
      else if (pclken)
      begin
         for (j = 0; j < 4; j = j + 1)
         begin
            if (irq_in_a[j] == irq_in_b[j])
               disc_cnt_reg[j] <= `FSI_CNT_ZERO;
            else if (disc_cnt_reg[j] < DISC_CYCLES)
               disc_cnt_reg[j] <= disc_cnt_reg[j] + 17'h0_0001;
            // Error set wins over a simultaneous clear
            if (irq_in_a[j] != irq_in_b[j] && disc_cnt_reg[j] >= DISC_CYCLES - 17'h0_0001)
               disc_err_reg[j] <= 1'b1;
            else if (wr_status && pwdata[`FSI_STAT_DISC_LSB + j])
               disc_err_reg[j] <= 1'b0;
         end
      end
   end

   // Async pending flags, dispatch and handler busy
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         async_pend_reg <= 4'h0;
         async_irq_handler <= 1'b0;
         async_irq_src <= 4'h0;
      end
      else if (pclken)
      begin
         // New arrivals in the dispatch cycle stay pending
         if (async_go)
            async_pend_reg <= async_evt;
         else
            async_pend_reg <= async_pend_reg | async_evt;
         if (async_go && async_loaded)
         begin
            async_irq_handler <= 1'b1;
            async_irq_src <= async_pend_reg;
         end
         else if (wr_hdone && pwdata[`FSI_HDONE_ASYNC])
            async_irq_handler <= 1'b0;
      end
   end

   // Sync pending flags, dispatch and handler busy
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_pend_reg <= 22'h00_0000;
         sync_irq_handler <= 1'b0;
         sync_irq_src <= 22'h00_0000;
      end
      else if (pclken)
      begin
         if (sync_go)
            sync_pend_reg <= sync_evt;
         else
            sync_pend_reg <= sync_pend_reg | sync_evt;
         if (sync_go && sync_loaded)
         begin
            sync_irq_handler <= 1'b1;
            sync_irq_src <= sync_pend_reg;
         end
         else if (wr_hdone && pwdata[`FSI_HDONE_SYNC])
            sync_irq_handler <= 1'b0;
      end
   end

   // Resume pulse when a dispatch finds no handler loaded
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         resume_pulse <= 1'b0;
      else if (pclken)
         resume_pulse <= (async_go & ~async_loaded) | (sync_go & ~sync_loaded);
   end

   // Cause and event logs; a new interrupt replaces the cause bits and adds to the event log, set beats clear
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cause_reg <= `FSI_ZERO8;
         evt_log_reg <= `FSI_ZERO8;
         sync_cause_reg <= 22'h00_0000;
      end
      else if (pclken)
      begin
         if (|async_evt)
            cause_reg <= {async_evt, 4'h0};
         else if (wr_cause)
            cause_reg <= cause_reg & ~pwdata[7:0];
         if (wr_evt && !async_irq_handler)
            evt_log_reg <= (evt_log_reg & ~pwdata[7:0]) | {async_evt, 4'h0};
         else
            evt_log_reg <= evt_log_reg | {async_evt, 4'h0};
         if (|sync_evt)
            sync_cause_reg <= sync_evt;
         else if (wr_scause)
            sync_cause_reg <= sync_cause_reg & ~pwdata[21:0];
      end
   end

   // Log of outputs reset by the async handler
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         out_rst_log_reg <= `FSI_ZERO8;
      else if (pclken)
      begin
         if (wr_orst && !async_irq_handler)
            out_rst_log_reg <= out_rst_log_reg & ~pwdata[7:0];
         else if (wr_out)
            out_rst_log_reg <= out_rst_log_reg | out_cleared;
      end
   end

   // Output byte, its enable and the input image
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_byte_enable <= 1'b1;
         onboard_out <= `FSI_ZERO8;
         input_image <= `FSI_ZERO8;
      end
      else if (pclken)
      begin
         out_byte_enable <= out_en_next;
         onboard_out <= out_en_next ? out_byte_reg : `FSI_ZERO8;
         if (|async_evt)
            input_image <= {async_evt, 4'h0};
         else
            input_image <= cause_reg;
      end
   end

   // Read data captured in the setup phase
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (pclken && rd_setup)
      begin
         prdata <= 32'h0000_0000;
         if (sel_idx(paddr, `FSI_IDX_CTRL))
            prdata[`FSI_CTRL_MSB:0] <= ctrl_reg;
         if (sel_idx(paddr, `FSI_IDX_SYNC_EN))
            prdata[19:0] <= sync_en_reg;
         if (sel_idx(paddr, `FSI_IDX_EDGE_LO))
            prdata <= edge_lo_reg;
         if (sel_idx(paddr, `FSI_IDX_EDGE_HI))
            prdata[9:0] <= edge_hi_reg;
         if (sel_idx(paddr, `FSI_IDX_SYNC_CAUSE))
            prdata[21:0] <= sync_cause_reg;
         if (sel_idx(paddr, `FSI_IDX_STATUS))
            prdata[7:0] <= {disc_err_reg, 1'b0, out_byte_enable, sync_irq_handler, async_irq_handler};
         if (sel_idx(paddr, `FSI_IDX_OUT_BYTE))
            prdata[7:0] <= out_byte_reg;
         if (sel_idx(paddr, `FSI_IDX_COMM))
            prdata[7:0] <= comm_reg;
         if (sel_idx(paddr, `FSI_IDX_EVT_LOG))
            prdata[7:0] <= evt_log_reg;
         if (sel_idx(paddr, `FSI_IDX_OUT_RST_LOG))
            prdata[7:0] <= out_rst_log_reg;
         if (sel_idx(paddr, `FSI_IDX_CAUSE))
            prdata[7:0] <= cause_reg;
      end
   end

endmodule // fsi_irq_logic
`default_nettype wire

/* File: bench/fsi_irq_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module fsi_irq_monitor (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Field inputs and controller state
   input wire logic [3:0] irq_in_a,
   input wire logic [3:0] irq_in_b,
   input wire logic powered,
   input wire logic run_mode,
   input wire logic insn_boundary,
   // Dispatch, output byte and image
   input wire logic async_irq_handler,
   input wire logic [3:0] async_irq_src,
   input wire logic resume_pulse,
   input wire logic [7:0] onboard_out,
   input wire logic out_byte_enable,
   input wire logic [7:0] input_image
);
   // Both channels of the first two dedicated inputs closed
   wire [1:0] closed = irq_in_a[1:0] & irq_in_b[1:0];

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_image_first:
   assert property ($rose(input_image[4]) |-> !$past(closed[0]) && $past(closed[0], 2))
      else $error("image bit 4 rose without a fall on input 0");
   a_image_second:
   assert property ($rose(input_image[5]) |-> !$past(closed[1]) && $past(closed[1], 2))
      else $error("image bit 5 rose without a fall on input 1");
   a_image_low_clear:
   assert property (input_image[3:0] == 4'h0)
      else $error("image low nibble not zero");
   a_dispatch_gated:
   assert property ($rose(async_irq_handler) |-> $past(powered) && $past(run_mode) && $past(insn_boundary))
      else $error("dispatch while gate closed");
   a_dispatch_source:
   assert property ($rose(async_irq_handler) |-> async_irq_src != 4'h0)
      else $error("dispatch without a source");
   a_src_held_busy:
   assert property (async_irq_handler && $past(async_irq_handler) |-> $stable(async_irq_src))
      else $error("running handler was preempted");
   a_resume_single:
   assert property (resume_pulse |=> !resume_pulse)
      else $error("resume pulse longer than one cycle");
   a_out_forced_off:
   assert property (!out_byte_enable |-> onboard_out == 8'h00)
      else $error("disabled output byte not zero");

   c_dispatch: cover property ($rose(async_irq_handler));
   c_resume: cover property (resume_pulse);
   c_passive: cover property ($fell(out_byte_enable));
endmodule // fsi_irq_monitor

bind fsi_irq_logic fsi_irq_monitor u_mon (
   .pclk(pclk), .presetn(presetn), .irq_in_a(irq_in_a), .irq_in_b(irq_in_b),
   .powered(powered), .run_mode(run_mode), .insn_boundary(insn_boundary),
   .async_irq_handler(async_irq_handler), .async_irq_src(async_irq_src), .resume_pulse(resume_pulse),
   .onboard_out(onboard_out), .out_byte_enable(out_byte_enable), .input_image(input_image)
);
`default_nettype wire

/* File: bench/fsi_sensors.sv */
`timescale 1ns/100ps
`default_nettype none
module fsi_sensors (
   // Clock
   input wire logic pclk,
   // Commands from the bench
   input wire logic [3:0] open_req,
   input wire logic [3:0] b_hold,
   // Two channels per sensor, high while closed
   output logic [3:0] ch_a = 4'hF,
   output logic [3:0] ch_b = 4'hF
);
   logic [3:0] d1 = 4'h0;
   logic [3:0] d2 = 4'h0;

   // Channel A opens at once, B two cycles later unless held stuck closed
   always @(posedge pclk)
   begin
      d1 <= open_req;
      d2 <= d1;
      ch_a <= ~open_req;
      ch_b <= ~(d2 & ~b_hold);
   end
endmodule // fsi_sensors
`default_nettype wire

/* File: bench/test_failsafe_interrupt_input_logic.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fsi_consts.vh"
module test_failsafe_interrupt_input_logic;
   localparam logic [7:0] A_CTRL = {`FSI_IDX_CTRL, 2'b00};
   localparam logic [7:0] A_HDONE = {`FSI_IDX_HDONE, 2'b00};
   localparam logic [7:0] A_STAT = {`FSI_IDX_STATUS, 2'b00};
   localparam logic [7:0] A_COMM = {`FSI_IDX_COMM, 2'b00};
   localparam logic [7:0] A_CAUSE = {`FSI_IDX_CAUSE, 2'b00};
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run_mode = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'hf621, rnd;
   logic [15:0] din = 16'h0;
   logic [3:0] open_req = 4'h0, b_hold = 4'h0, irq_a, irq_b, async_irq_src;
   logic pready, pslverr, async_irq_handler, resume_pulse, out_byte_enable, h_prev = 1'b0;
   logic [7:0] input_image, onboard_out;
   logic pclken = 1'b1, powered = 1'b1, insn_boundary = 1'b1, sync_irq_handler;
   logic [1:0] cnt_match = 2'b00;
   logic [21:0] sync_irq_src;
   logic [32:0] rd_q[$];
   logic [4:0] ev_q[$];
   int n_fail = 0;
   int n_compared = 0;

   fsi_sensors u_sens (.pclk(pclk), .open_req(open_req), .b_hold(b_hold), .ch_a(irq_a), .ch_b(irq_b));
   fsi_irq_logic #(.DISC_CYCLES(17'd20)) u_dut (
      .pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq_in_a(irq_a), .irq_in_b(irq_b), .digital_input_a(din), .digital_input_b(din), .cnt_match(cnt_match),
      .powered(powered), .run_mode(run_mode), .insn_boundary(insn_boundary), .async_irq_handler(async_irq_handler),
      .async_irq_src(async_irq_src), .sync_irq_handler(sync_irq_handler), .sync_irq_src(sync_irq_src),
      .resume_pulse(resume_pulse), .onboard_out(onboard_out), .out_byte_enable(out_byte_enable),
      .input_image(input_image));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
      n_compared++;
      if (g !== e)
      begin
         n_fail++;
         $display("unexpected read: expected %h seen %h", e, g);
      end
   endtask

   task automatic cmp_ev(input logic [4:0] e, input logic [4:0] g);
      n_compared++;
      if (g !== e)
      begin
         n_fail++;
         $display("unexpected dispatch: expected %h seen %h", e, g);
      end
   endtask

   task automatic cmp_pin(input string name, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e)
      begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", name, e, g);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50)
      begin
         @(posedge pclk);
         n++;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      rd_q.push_back(e);
      apb(1'b0, a, 32'h0000_0000);
   endtask

   // Open a sensor for 30 cycles, optionally with channel B stuck closed
   task automatic trip(input int i, input logic hold);
      @(posedge pclk);
      b_hold[i] <= hold;
      open_req[i] <= 1'b1;
      repeat (30) @(posedge pclk);
      open_req[i] <= 1'b0;
      b_hold[i] <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask

   task automatic settle;
      int n;
      n = 0;
      while (ev_q.size() != 0 && n < 80)
      begin
         @(posedge pclk);
         n++;
      end
   endtask

   task automatic summarize;
      if (n_fail == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always #5 pclk = ~pclk;

   // Random onboard inputs, same on both subunits
   always @(posedge pclk)
   begin
      lfsr <= lfsr_next(lfsr);
      din <= lfsr[15:0];
   end

   // Result watcher: read data and dispatches against the oldest note
   always @(posedge pclk)
   begin
      if (psel && penable && pready && !pwrite)
         cmp_rd(rd_q.size() != 0 ? rd_q.pop_front() : 33'hx, {pslverr, prdata});
      if ((async_irq_handler && !h_prev) || resume_pulse)
         cmp_ev(ev_q.size() != 0 ? ev_q.pop_front() : 5'hx, {resume_pulse, resume_pulse ? 4'h0 : async_irq_src});
      h_prev = async_irq_handler;
   end

   // Main sequence
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(A_CTRL, 33'h0_0000_0080);
      apb(1'b1, A_CTRL, 32'h0000_00BF);
      ev_q.push_back(5'h01);
      trip(0, 1'b0);
      #1 cmp_pin("image", 8'h10, input_image);
      rd(A_CAUSE, 33'h0_0000_0010);
      ev_q.push_back(5'h02);
      trip(1, 1'b0);
      apb(1'b1, A_HDONE, 32'h0000_0001);
      settle;
      rd(A_CAUSE, 33'h0_0000_0020);
      apb(1'b1, A_HDONE, 32'h0000_0001);
      apb(1'b1, A_CTRL, 32'h0000_003F);
      trip(2, 1'b0);
      trip(2, 1'b0);
      ev_q.push_back(5'h04);
      apb(1'b1, A_CTRL, 32'h0000_00BF);
      settle;
      apb(1'b1, A_HDONE, 32'h0000_0001);
      run_mode <= 1'b0;
      trip(3, 1'b0);
      ev_q.push_back(5'h08);
      run_mode <= 1'b1;
      settle;
      apb(1'b1, A_HDONE, 32'h0000_0001);
      apb(1'b1, A_CAUSE, 32'h0000_00FF);
      apb(1'b1, A_CTRL, 32'h0000_00BE);
      trip(0, 1'b0);
      rd(A_CAUSE, 33'h0_0000_0000);
      apb(1'b1, A_CTRL, 32'h0000_009F);
      ev_q.push_back(5'h10);
      trip(3, 1'b1);
      rd(A_STAT, 33'h0_0000_0084);
      apb(1'b1, A_STAT, 32'h0000_00F0);
      rd(A_STAT, 33'h0_0000_0004);
      apb(1'b1, A_CTRL, 32'h0000_02BF);
      repeat (2) @(posedge pclk);
      #1 cmp_pin("out_enable", 8'h01, {7'h0, out_byte_enable});
      apb(1'b1, A_CTRL, 32'h0000_03BF);
      repeat (2) @(posedge pclk);
      #1 cmp_pin("out_enable", 8'h00, {7'h0, out_byte_enable});
      rnd = lfsr;
      apb(1'b1, A_COMM, rnd);
      rd(A_COMM, {25'h0, rnd[7:0]});
      rd(8'hFC, {1'b1, 32'h0000_0000});
      settle;
      repeat (4) @(posedge pclk);
      summarize;
   end

   // Watchdog
   initial
   begin
      repeat (4000) @(posedge pclk);
      n_fail++;
      summarize;
   end
endmodule // test_failsafe_interrupt_input_logic
`default_nettype wire
